// ===== src/idle_res_pkg.sv
package idle_res_pkg;

  // core idle-state codes, ordered from shallow to deep
  localparam int STATE_W = 3;
  localparam logic [2:0] CORE_C0 = 3'h0;
  localparam logic [2:0] CORE_C1 = 3'h1;
  localparam logic [2:0] CORE_C1E = 3'h2;
  localparam logic [2:0] CORE_C3 = 3'h3;
  localparam logic [2:0] CORE_C6 = 3'h4;
  localparam logic [2:0] CORE_C7 = 3'h5;

  // package idle-state codes, ordered from shallow to deep
  localparam logic [2:0] PKG_C0 = 3'h0;
  localparam logic [2:0] PKG_C1 = 3'h1;
  localparam logic [2:0] PKG_C1E = 3'h2;
  localparam logic [2:0] PKG_C2 = 3'h3;
  localparam logic [2:0] PKG_C3 = 3'h4;
  localparam logic [2:0] PKG_C6 = 3'h5;

  // register offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] CORES_OFF = 12'h008;

  // control register fields
  localparam int CTRL_C1E_EN_BIT = 0;
  localparam int CTRL_AUTOPROMO_BIT = 1;
  localparam int CTRL_HEUR_BIT = 2;
  localparam int CTRL_LIMIT_LSB = 4;
  localparam logic [2:0] CTRL_LIMIT_RST = 3'h5;
  localparam logic [2:0] CTRL_FLAGS_RST = 3'h1;

  // status register fields
  localparam int ST_PKG_LSB = 0;
  localparam int ST_REQ_LSB = 4;
  localparam int ST_MEMWAKE_BIT = 8;
  localparam int ST_BRKWAKE_BIT = 9;
  localparam int ST_FREQ_BIT = 16;
  localparam int ST_VOLT_BIT = 17;
  localparam int ST_LLC_RET_BIT = 18;
  localparam int ST_FLUSH_BIT = 19;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int VSTEP_DELAY_NS = 100;
  localparam int VSTEP_CYCLES = (VSTEP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROMOTE_RES_NS = 50000;
  localparam int PROMOTE_CYCLES = (PROMOTE_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROMOTE_W = 12;
  localparam int VSTEP_W = 4;

endpackage : idle_res_pkg

// ===== src/core_state_min.sv
`timescale 1ns/1ps
`default_nettype none

module core_state_min #(
  parameter int NUM_CORES = 2
) (
  // per-core resolved states, core 0 in the low bits
  input wire logic [NUM_CORES*3-1:0] core_state,
  // reductions
  output logic [2:0] min_state,
  output logic all_c1e_hint,
  output logic any_c6_req
);

  logic [2:0] min_chain [0:NUM_CORES];
  logic hint_chain [0:NUM_CORES];
  logic c6_chain [0:NUM_CORES];

  assign min_chain[0] = idle_res_pkg::CORE_C7;
  assign hint_chain[0] = 1'b1;
  assign c6_chain[0] = 1'b0;

  // lowest state wins across all cores
  for (genvar i = 0; i < NUM_CORES; i++) begin : g_core
    wire logic [2:0] cs = core_state[i*3 +: 3];
    assign min_chain[i+1] = (cs < min_chain[i]) ? cs : min_chain[i];
    assign hint_chain[i+1] = hint_chain[i] && (cs == idle_res_pkg::CORE_C1E);
    assign c6_chain[i+1] = c6_chain[i] || (cs == idle_res_pkg::CORE_C6);
  end

  assign min_state = min_chain[NUM_CORES];
  assign all_c1e_hint = hint_chain[NUM_CORES];
  assign any_c6_req = c6_chain[NUM_CORES];

endmodule : core_state_min

`default_nettype wire

// ===== src/package_idle_state_resolver.sv
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module package_idle_state_resolver #(
  parameter int NUM_CORES = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core and graphics idle states
  input wire logic [NUM_CORES*3-1:0] core_state,
  input wire logic gfx_deep,
  // platform power controller
  input wire logic plat_grant,
  input wire logic [2:0] plat_limit,
  input wire logic plat_hold_shallow,
  input wire logic latency_block,
  input wire logic mem_req,
  input wire logic mem_busy,
  // break events
  input wire logic break_valid,
  input wire logic [((NUM_CORES > 1) ? $clog2(NUM_CORES) : 1)-1:0] break_core,
  input wire logic break_masked,
  // package results
  output logic [2:0] pkg_state,
  output logic [2:0] pkg_request,
  output logic [NUM_CORES-1:0] core_wake,
  output logic break_fwd,
  output logic [((NUM_CORES > 1) ? $clog2(NUM_CORES) : 1)-1:0] break_fwd_core,
  output logic freq_min_req,
  output logic volt_low_req,
  output logic plat_notify,
  output logic llc_retain,
  output logic llc_flush_ok,
  output logic core_volt_off
);

  localparam int CID_W = (NUM_CORES > 1) ? $clog2(NUM_CORES) : 1;
  localparam int PROMOTE_W_L = idle_res_pkg::PROMOTE_W;
  localparam logic [PROMOTE_W_L-1:0] PROMOTE_LAST =
    PROMOTE_W_L'(idle_res_pkg::PROMOTE_CYCLES - 1);
  localparam logic [idle_res_pkg::VSTEP_W-1:0] VSTEP_LAST =
    idle_res_pkg::VSTEP_W'(idle_res_pkg::VSTEP_CYCLES);

  typedef enum logic [1:0] {ST_RESOLVE, ST_BRK_WAKE, ST_BRK_RET, ST_MEM_WAKE} res_state_t;

  res_state_t st_ff;
  res_state_t nxt_st;
  logic [2:0] pkg_ff;
  logic [2:0] nxt_pkg;
  logic [2:0] saved_ff;
  logic [2:0] nxt_saved;
  logic [2:0] req_ff;
  logic [2:0] limit_ff;
  logic c1e_en_ff;
  logic autopromo_ff;
  logic heur_ff;
  logic [PROMOTE_W_L-1:0] res_cnt_ff;
  logic [idle_res_pkg::VSTEP_W-1:0] vf_cnt_ff;
  logic freq_ff;
  logic volt_ff;
  logic notify_ff;
  logic retain_ff;
  logic flush_ff;
  logic voff_ff;
  logic brk_ff;
  logic [CID_W-1:0] brk_core_ff;
  logic [NUM_CORES-1:0] wake_ff;
  logic [31:0] prdata_ff;

  // core reduction
  wire logic [2:0] min_req;
  wire logic all_hint;
  wire logic any_c6;

  core_state_min #(
    .NUM_CORES(NUM_CORES)
  ) u_min (
    .core_state(core_state),
    .min_state(min_req),
    .all_c1e_hint(all_hint),
    .any_c6_req(any_c6)
  );

  // target resolution
  wire logic [2:0] cap = (limit_ff < plat_limit) ? limit_ff : plat_limit;
  wire logic req_deep = (min_req >= idle_res_pkg::CORE_C3);
  wire logic deep_ok = req_deep && gfx_deep;
  wire logic c1e_sel = c1e_en_ff && (all_hint || autopromo_ff || req_deep);
  wire logic [2:0] tgt_c1 = c1e_sel ? idle_res_pkg::PKG_C1E : idle_res_pkg::PKG_C1;
  wire logic promote = heur_ff && (res_cnt_ff == PROMOTE_LAST) &&
                       (cap >= idle_res_pkg::PKG_C6);
  wire logic want_c6 = (min_req >= idle_res_pkg::CORE_C6) && (cap >= idle_res_pkg::PKG_C6);
  wire logic [2:0] target =
    ((min_req == idle_res_pkg::CORE_C0) || !plat_grant ||
     (cap == idle_res_pkg::PKG_C0)) ? idle_res_pkg::PKG_C0 :
    (!deep_ok || (cap <= idle_res_pkg::PKG_C1E)) ? tgt_c1 :
    (latency_block || (cap == idle_res_pkg::PKG_C2)) ? idle_res_pkg::PKG_C2 :
    (want_c6 || promote) ? idle_res_pkg::PKG_C6 :
    idle_res_pkg::PKG_C3;
  wire logic [2:0] ret_state = (saved_ff < target) ? saved_ff : target;
  wire logic pkg_deep = (pkg_ff == idle_res_pkg::PKG_C3) || (pkg_ff == idle_res_pkg::PKG_C6);
  wire logic mem_wake_go = mem_req && pkg_deep && deep_ok && plat_grant;
  wire logic mem_stay = mem_req || mem_busy || plat_hold_shallow;

  // sequencing of break and memory wakes
  always_comb begin
    nxt_st = st_ff;
    nxt_pkg = pkg_ff;
    nxt_saved = saved_ff;
    unique case (st_ff)
      ST_RESOLVE: begin
        if (break_valid) begin
          nxt_saved = pkg_ff;
          nxt_pkg = idle_res_pkg::PKG_C0;
          nxt_st = break_masked ? ST_BRK_RET : ST_BRK_WAKE;
        end else if (mem_wake_go) begin
          nxt_saved = pkg_ff;
          nxt_pkg = idle_res_pkg::PKG_C2;
          nxt_st = ST_MEM_WAKE;
        end else begin
          nxt_pkg = target;
        end
      end
      ST_BRK_WAKE: begin
        nxt_pkg = idle_res_pkg::PKG_C0;
        if (min_req == idle_res_pkg::CORE_C0) begin
          nxt_st = ST_RESOLVE;
        end
      end
      ST_BRK_RET: begin
        nxt_pkg = ret_state;
        nxt_st = ST_RESOLVE;
      end
      ST_MEM_WAKE: begin
        if (mem_stay) begin
          nxt_pkg = idle_res_pkg::PKG_C2;
        end else begin
          nxt_pkg = ret_state;
          nxt_st = ST_RESOLVE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RESOLVE;
      pkg_ff <= idle_res_pkg::PKG_C0;
      saved_ff <= idle_res_pkg::PKG_C0;
      req_ff <= idle_res_pkg::CORE_C0;
    end else begin
      st_ff <= nxt_st;
      pkg_ff <= nxt_pkg;
      saved_ff <= nxt_saved;
      req_ff <= min_req;
    end
  end

  // residency counter for heuristic promotion
  wire logic res_run = heur_ff && (min_req == idle_res_pkg::CORE_C3);
  wire logic [PROMOTE_W_L-1:0] nxt_res_cnt =
    !res_run ? '0 : (res_cnt_ff == PROMOTE_LAST) ? res_cnt_ff : res_cnt_ff + 1'b1;

  // enhanced state 1: frequency drop, then voltage after a settle time
  wire logic in_c1e = (pkg_ff == idle_res_pkg::PKG_C1E);
  wire logic [idle_res_pkg::VSTEP_W-1:0] nxt_vf_cnt =
    !in_c1e ? '0 : (vf_cnt_ff == VSTEP_LAST) ? vf_cnt_ff : vf_cnt_ff + 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_cnt_ff <= '0;
      vf_cnt_ff <= '0;
      freq_ff <= 1'b0;
      volt_ff <= 1'b0;
    end else begin
      res_cnt_ff <= nxt_res_cnt;
      vf_cnt_ff <= nxt_vf_cnt;
      freq_ff <= in_c1e;
      volt_ff <= in_c1e && (vf_cnt_ff == VSTEP_LAST);
    end
  end

  // platform notification, cache policy and core power
  wire logic nxt_notify = (nxt_pkg != pkg_ff) && (nxt_pkg >= idle_res_pkg::PKG_C2);
  wire logic nxt_is_c6 = (nxt_pkg == idle_res_pkg::PKG_C6);
  wire logic nxt_flush = nxt_is_c6 && !any_c6 && (min_req >= idle_res_pkg::CORE_C7);
  wire logic [NUM_CORES-1:0] wake_vec = NUM_CORES'(1) << break_core;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      notify_ff <= 1'b0;
      retain_ff <= 1'b1;
      flush_ff <= 1'b0;
      voff_ff <= 1'b0;
      brk_ff <= 1'b0;
      brk_core_ff <= '0;
      wake_ff <= '0;
    end else begin
      notify_ff <= nxt_notify;
      retain_ff <= !nxt_flush;
      flush_ff <= nxt_flush;
      voff_ff <= nxt_is_c6;
      brk_ff <= break_valid;
      brk_core_ff <= break_core;
      wake_ff <= break_valid ? wake_vec : '0;
    end
  end

  // apb register access
  wire logic setup = psel && !penable;
  wire logic access = psel && penable;
  wire logic hit_ctrl = (paddr == idle_res_pkg::CTRL_OFF);
  wire logic hit_status = (paddr == idle_res_pkg::STATUS_OFF);
  wire logic hit_cores = (paddr == idle_res_pkg::CORES_OFF);
  wire logic mapped = hit_ctrl || hit_status || hit_cores;
  wire logic wr_ctrl = access && pwrite && hit_ctrl;
  wire logic [2:0] wr_limit = pwdata[idle_res_pkg::CTRL_LIMIT_LSB +: 3];
  wire logic limit_ok = (wr_limit != idle_res_pkg::PKG_C2) &&
                        (wr_limit <= idle_res_pkg::PKG_C6);

  wire logic [31:0] ctrl_rd = {25'h0, limit_ff, 1'b0, heur_ff, autopromo_ff, c1e_en_ff};
  wire logic [31:0] status_rd = {12'h0, flush_ff, retain_ff, volt_ff, freq_ff,
                                 6'h0, (st_ff == ST_BRK_WAKE), (st_ff == ST_MEM_WAKE),
                                 1'b0, req_ff, 1'b0, pkg_ff};
  wire logic [31:0] cores_rd = 32'(core_state);
  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_rd : hit_status ? status_rd :
                             hit_cores ? cores_rd : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1e_en_ff <= idle_res_pkg::CTRL_FLAGS_RST[idle_res_pkg::CTRL_C1E_EN_BIT];
      autopromo_ff <= idle_res_pkg::CTRL_FLAGS_RST[idle_res_pkg::CTRL_AUTOPROMO_BIT];
      heur_ff <= idle_res_pkg::CTRL_FLAGS_RST[idle_res_pkg::CTRL_HEUR_BIT];
      limit_ff <= idle_res_pkg::CTRL_LIMIT_RST;
      prdata_ff <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        c1e_en_ff <= pwdata[idle_res_pkg::CTRL_C1E_EN_BIT];
        autopromo_ff <= pwdata[idle_res_pkg::CTRL_AUTOPROMO_BIT];
        heur_ff <= pwdata[idle_res_pkg::CTRL_HEUR_BIT];
        if (limit_ok) begin
          limit_ff <= wr_limit;
        end
      end
      if (setup && !pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  assign pkg_state = pkg_ff;
  assign pkg_request = req_ff;
  assign core_wake = wake_ff;
  assign break_fwd = brk_ff;
  assign break_fwd_core = brk_core_ff;
  assign freq_min_req = freq_ff;
  assign volt_low_req = volt_ff;
  assign plat_notify = notify_ff;
  assign llc_retain = retain_ff;
  assign llc_flush_ok = flush_ff;
  assign core_volt_off = voff_ff;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_REQ_LOWEST: assert property (
    ##1 pkg_request <= $past(core_state[2:0])
  ) else $error("package request deeper than core 0");

  AST_NO_GRANT_ACTIVE: assert property (
    (st_ff == ST_RESOLVE) && !plat_grant && !break_valid |=> pkg_state == idle_res_pkg::PKG_C0
  ) else $error("package left active state without grant");

  AST_BREAK_FORWARD: assert property (
    break_valid |=> break_fwd && core_wake[break_fwd_core] && ($countones(core_wake) == 1)
  ) else $error("break event not forwarded to its core");

  AST_UNMASKED_ACTIVE: assert property (
    (st_ff == ST_RESOLVE) && break_valid && !break_masked
      |=> (pkg_state == idle_res_pkg::PKG_C0) [*2]
  ) else $error("unmasked break did not make package active");

  AST_MASKED_RETURN: assert property (
    (st_ff == ST_RESOLVE) && break_valid && break_masked
      |=> (pkg_state == idle_res_pkg::PKG_C0) ##1 (st_ff == ST_RESOLVE)
  ) else $error("masked break did not return at once");

  AST_VOLT_AFTER_FREQ: assert property (
    $rose(volt_low_req) |-> freq_min_req && $past(freq_min_req, idle_res_pkg::VSTEP_CYCLES)
  ) else $error("voltage lowered before frequency settled");

  AST_NO_NOTIFY_C1: assert property (
    plat_notify |-> pkg_state >= idle_res_pkg::PKG_C2
  ) else $error("notification sent for shallow state");

  AST_MEM_DROP_C2: assert property (
    (st_ff == ST_RESOLVE) && !break_valid && mem_wake_go
      |=> (pkg_state == idle_res_pkg::PKG_C2) && (st_ff == ST_MEM_WAKE)
  ) else $error("memory wake did not drop to state 2");

  AST_HOLD_SHALLOW: assert property (
    (st_ff == ST_MEM_WAKE) && plat_hold_shallow |=> pkg_state == idle_res_pkg::PKG_C2
  ) else $error("package left state 2 under platform hold");

  AST_LLC_KEPT: assert property (
    (pkg_state == idle_res_pkg::PKG_C3) |-> llc_retain && !llc_flush_ok
  ) else $error("cache not kept in state 3");

  AST_C2_NOT_SW: assert property (
    limit_ff != idle_res_pkg::PKG_C2
  ) else $error("software limit holds state 2");

endmodule : package_idle_state_resolver

`default_nettype wire

// ===== bench/plat_power_model.sv
`timescale 1ns/1ps
`default_nettype none

module plat_power_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench controls
  input wire logic grant_en,
  input wire logic [2:0] lim_cfg,
  input wire logic hold_req,
  input wire logic lat_req,
  input wire logic mem_kick,
  input wire logic [3:0] busy_len,
  // toward the resolver
  output logic plat_grant,
  output logic [2:0] plat_limit,
  output logic plat_hold_shallow,
  output logic latency_block,
  output logic mem_req,
  output logic mem_busy
);
  logic [3:0] busy_ff;

  assign mem_busy = busy_ff != 4'h0;

  // levels change only just after an edge and then stand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plat_grant <= 1'b0;
      plat_limit <= 3'h0;
      plat_hold_shallow <= 1'b0;
      latency_block <= 1'b0;
      mem_req <= 1'b0;
      busy_ff <= 4'h0;
    end else begin
      plat_grant <= grant_en;
      plat_limit <= lim_cfg;
      plat_hold_shallow <= hold_req;
      latency_block <= lat_req;
      mem_req <= mem_kick;
      busy_ff <= mem_kick ? busy_len : busy_ff - {3'h0, mem_busy};
    end
  end
endmodule : plat_power_model

`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, c0_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] core_state;
  logic [2:0] pkg_state, pkg_request, plim, plat_limit, prev_exp;
  logic [1:0] core_wake;
  logic [0:0] break_core, break_fwd_core;
  logic [3:0] blen;
  logic [7:0] cur_ctrl;
  logic gfx_deep, break_valid, break_masked, break_fwd, freq_min_req, volt_low_req;
  logic plat_notify, llc_retain, llc_flush_ok, core_volt_off;
  logic grant, hold, lat, kick, plat_grant, plat_hold_shallow, latency_block, mem_req, mem_busy;
  int bad_count, checks_done, notes, k;

  package_idle_state_resolver #(.NUM_CORES(2)) package_idle_state_resolver_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_state,
    .gfx_deep, .plat_grant, .plat_limit, .plat_hold_shallow, .latency_block, .mem_req,
    .mem_busy, .break_valid, .break_core, .break_masked, .pkg_state, .pkg_request,
    .core_wake, .break_fwd, .break_fwd_core, .freq_min_req, .volt_low_req, .plat_notify,
    .llc_retain, .llc_flush_ok, .core_volt_off);

  plat_power_model plat_power_model_i (.pclk, .presetn, .grant_en(grant), .lim_cfg(plim),
    .hold_req(hold), .lat_req(lat), .mem_kick(kick), .busy_len(blen), .plat_grant,
    .plat_limit, .plat_hold_shallow, .latency_block, .mem_req, .mem_busy);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) if (plat_notify === 1'b1) notes++;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask : apb

  // 0 freq low, 1 volt low, 2 C2, 3 C6
  function automatic logic pick(input int w);
    case (w)
      0: pick = freq_min_req === 1'h1;
      1: pick = volt_low_req === 1'h1;
      2: pick = pkg_state === 3'h3;
      default: pick = pkg_state === 3'h5;
    endcase
  endfunction : pick

  task automatic wt(input int w, input int lim);
    k = 0;
    while (!pick(w) && k < lim) begin @(posedge pclk); #1; k++; end
  endtask : wt

  // core codes 0..5 = C0 C1 C1E C3 C6 C7; package 0..5 = C0 C1 C1E C2 C3 C6
  task automatic run_case(input logic [7:0] ctl, input logic g, input logic [2:0] pl,
                          input logic lt, input logic [2:0] a1, a0, e);
    int n0;
    logic fl;
    if (ctl !== cur_ctrl) begin apb(1'h1, 12'h000, {24'h0, ctl}); cur_ctrl = ctl; end
    n0 = notes;
    @(posedge pclk);
    grant <= g; plim <= pl; lat <= lt; core_state <= {a1, a0};
    c0_seen = 1'h0;
    repeat (4) begin @(posedge pclk); #1; if (pkg_state === 3'h0) c0_seen = 1'h1; end
    fl = (e == 3'h5) && (a0 == 3'h5) && (a1 == 3'h5);
    `CHK("pkg_state", e, pkg_state)
    if (prev_exp != 3'h0 && e != 3'h0) `CHK("no_active_pass", 1'h0, c0_seen)
    if (e == 3'h1 || e == 3'h2) `CHK("notify", n0, notes)
    if (e >= 3'h3 && e != prev_exp) `CHK("notify_deep", n0 + 1, notes)
    `CHK("pkg_request", (a1 < a0) ? a1 : a0, pkg_request)
    `CHK("freq_min", e == 3'h2, freq_min_req)
    `CHK("flush_ok", fl, llc_flush_ok)
    `CHK("llc_retain", !fl, llc_retain)
    `CHK("core_volt_off", e == 3'h5, core_volt_off)
    prev_exp = e;
  endtask : run_case

  initial begin
    repeat (12000) @(posedge pclk);
    bad_count++;
    $display("watchdog expired");
    give_verdict();
  end

  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h000;
    pwdata = 32'h0; core_state = 6'h00; gfx_deep = 1'h1; break_valid = 1'h0;
    break_core = 1'h0; break_masked = 1'h0; grant = 1'h0; plim = 3'h5; hold = 1'h0;
    lat = 1'h0; kick = 1'h0; blen = 4'h3; cur_ctrl = 8'h51; prev_exp = 3'h0;
    bad_count = 0; checks_done = 0; notes = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    `CHK("ctrl_reset", 32'h51, rd)
    apb(1'h0, 12'h00C, 32'h0);
    `CHK("unmapped_err", 1'h1, err)
    `CHK("unmapped_data", 32'h0, rd)
    $display("test registers done");
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h0, 3'h4, 3'h0);
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h1, 3'h1, 3'h1);
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h1, 3'h4, 3'h1);
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h2, 3'h2, 3'h2);
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h3, 3'h1, 3'h1);
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h4, 3'h4, 3'h5);
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h3, 3'h4, 3'h4);
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h5, 3'h5, 3'h5);
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h4, 3'h5, 3'h5);
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h3, 3'h3, 3'h4);
    run_case(8'h51, 1'h0, 3'h5, 1'h0, 3'h4, 3'h4, 3'h0);
    run_case(8'h51, 1'h1, 3'h4, 1'h0, 3'h4, 3'h4, 3'h4);
    run_case(8'h51, 1'h1, 3'h5, 1'h1, 3'h3, 3'h3, 3'h3);
    run_case(8'h53, 1'h1, 3'h5, 1'h0, 3'h1, 3'h1, 3'h2);
    run_case(8'h50, 1'h1, 3'h5, 1'h0, 3'h2, 3'h2, 3'h1);
    run_case(8'h21, 1'h1, 3'h5, 1'h0, 3'h4, 3'h4, 3'h2);
    apb(1'h1, 12'h000, 32'h31);
    apb(1'h0, 12'h000, 32'h0);
    `CHK("limit_refused", 32'h21, rd)
    $display("test resolution table done");
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h0, 3'h0, 3'h0);
    @(posedge pclk);
    core_state <= 6'h12;
    wt(0, 20);
    `CHK("freq_min", 3'h2, pkg_state)
    `CHK("volt_after_freq", 1'h0, volt_low_req)
    wt(1, 20);
    `CHK("volt_lag", idle_res_pkg::VSTEP_CYCLES, k)
    $display("test enhanced state done");
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h4, 3'h4, 3'h5);
    apb(1'h0, 12'h004, 32'h0);
    `CHK("status_pkg", 3'h5, rd[2:0])
    `CHK("status_req", 3'h4, rd[6:4])
    apb(1'h0, 12'h008, 32'h0);
    `CHK("cores_reg", 6'h24, rd[5:0])
    @(posedge pclk);
    kick <= 1'h1;
    @(posedge pclk);
    kick <= 1'h0;
    wt(2, 10);
    `CHK("mem_wake", 3'h3, pkg_state)
    wt(3, 20);
    `CHK("mem_return", 3'h5, pkg_state)
    @(posedge pclk);
    hold <= 1'h1; kick <= 1'h1;
    @(posedge pclk);
    kick <= 1'h0;
    wt(2, 10);
    repeat (10) @(posedge pclk);
    #1;
    `CHK("hold_shallow", 3'h3, pkg_state)
    apb(1'h0, 12'h004, 32'h0);
    `CHK("status_memwake", 1'h1, rd[8])
    @(posedge pclk);
    hold <= 1'h0;
    wt(3, 20);
    `CHK("hold_release", 3'h5, pkg_state)
    $display("test memory wake done");
    @(posedge pclk);
    break_valid <= 1'h1; break_core <= 1'h1; break_masked <= 1'h0;
    @(posedge pclk);
    break_valid <= 1'h0;
    #1;
    `CHK("break_pkg", 3'h0, pkg_state)
    `CHK("break_fwd", 1'h1, break_fwd)
    `CHK("break_core", 1'h1, break_fwd_core)
    `CHK("core_wake", 2'h2, core_wake)
    repeat (3) @(posedge pclk);
    #1;
    `CHK("break_hold", 3'h0, pkg_state)
    `CHK("wake_pulse", 2'h0, core_wake)
    apb(1'h0, 12'h004, 32'h0);
    `CHK("status_brkwake", 1'h1, rd[9])
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h0, 3'h4, 3'h0);
    run_case(8'h51, 1'h1, 3'h5, 1'h0, 3'h4, 3'h4, 3'h5);
    @(posedge pclk);
    break_valid <= 1'h1; break_core <= 1'h0; break_masked <= 1'h1;
    @(posedge pclk);
    break_valid <= 1'h0;
    #1;
    `CHK("masked_wake", 2'h1, core_wake)
    @(posedge pclk);
    #1;
    `CHK("masked_return", 3'h5, pkg_state)
    $display("test break events done");
    run_case(8'h55, 1'h1, 3'h5, 1'h0, 3'h3, 3'h3, 3'h4);
    wt(3, 2100);
    `CHK("promoted", 3'h5, pkg_state)
    `CHK("promote_wait", 1'h1, k > idle_res_pkg::PROMOTE_CYCLES - 10)
    $display("test heuristic promotion done");
    give_verdict();
  end
endmodule : tb

`default_nettype wire
